// >>> hw/autoclass_defs.vh
`ifndef AUTOCLASS_DEFS_VH
`define AUTOCLASS_DEFS_VH

`define CMD_AUTOCLASS_CONTROL 8'h50
`define CMD_CH1_AUTOCLASS_POWER 8'h51
`define CMD_CH2_AUTOCLASS_POWER 8'h52
`define CMD_CH3_AUTOCLASS_POWER 8'h53
`define CMD_CH4_AUTOCLASS_POWER 8'h54
`define CMD_ALT_FOLDBACK_SELECT 8'h55

`define RST_AUTOCLASS_CONTROL 8'h00
`define RST_ALT_FOLDBACK_SELECT 8'h00
`define RST_POWER 7'h00

`define REQ_MSB 7
`define REQ_LSB 4
`define ADJ_MSB 3
`define ADJ_LSB 0

`define CLK_PERIOD_NS 5
`define START_LIMIT_MS 10
`define CLEAR_LIMIT_MS 1
`define ADJUST_LIMIT_MS 5
`define NS_PER_MS 1000000
`define START_CYCLES (`START_LIMIT_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define CLEAR_CYCLES (`CLEAR_LIMIT_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define ADJUST_CYCLES (`ADJUST_LIMIT_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define CNT_W 24

`endif

// >>> hw/autoclass_channel.v
`timescale 1ns/1ps
`include "autoclass_defs.vh"
module autoclass_channel
#(
  parameter [`CNT_W-1:0] start_cycles = `START_CYCLES,
  parameter [`CNT_W-1:0] adjust_cycles = `ADJUST_CYCLES
)
(
  input wire mclk,
  input wire sys_rst,
  input wire request,
  input wire auto_adjust,
  input wire channel_on,
  input wire turn_on_event,
  input wire meas_busy,
  input wire meas_done,
  input wire [6:0] meas_power,
  output reg meas_start,
  output reg clear_request,
  output reg [6:0] measured_power_count,
  output reg adjust_valid,
  output reg [6:0] adjust_power
);
  localparam st_idle = 2'd0;
  localparam st_wait = 2'd1;
  localparam st_meas = 2'd2;
  reg [1:0] state;
  reg [`CNT_W-1:0] wait_cnt;
  reg adj_pending;
  reg [`CNT_W-1:0] adj_cnt;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= st_idle;
      wait_cnt <= {`CNT_W{1'b0}};
      meas_start <= 1'b0;
      clear_request <= 1'b0;
      measured_power_count <= `RST_POWER;
      adj_pending <= 1'b0;
      adj_cnt <= {`CNT_W{1'b0}};
      adjust_valid <= 1'b0;
      adjust_power <= `RST_POWER;
    end
    else
    begin
      meas_start <= 1'b0;
      clear_request <= 1'b0;
      adjust_valid <= 1'b0;
      if (turn_on_event && request)
      begin
        // Request held over from before turn-on is dropped
        clear_request <= 1'b1;
        state <= st_idle;
      end
      else
      begin
        case (state)
          st_idle:
          begin
            // A cleared bit still reads set for one more cycle; never restart on it
            if (request && channel_on && !clear_request)
            begin
              state <= st_wait;
              wait_cnt <= {`CNT_W{1'b0}};
            end
          end
          st_wait:
          begin
            // Start as soon as the engine is free, never past the limit
            if (!meas_busy || wait_cnt == start_cycles - 1'b1)
            begin
              meas_start <= 1'b1;
              state <= st_meas;
            end
            wait_cnt <= wait_cnt + 1'b1;
          end
          st_meas:
          begin
            if (meas_done)
            begin
              state <= st_idle;
              clear_request <= 1'b1;
            end
          end
          default:
          begin
            state <= st_idle;
          end
        endcase
      end
      if (meas_done && state == st_meas)
      begin
        measured_power_count <= meas_power;
        if (auto_adjust)
        begin
          adj_pending <= 1'b1;
          adj_cnt <= {`CNT_W{1'b0}};
        end
      end
      else if (adj_pending)
      begin
        // Threshold update issued well inside the window
        if (adj_cnt == adjust_cycles - 1'b1 || adj_cnt[0])
        begin
          adj_pending <= 1'b0;
          adjust_valid <= 1'b1;
          adjust_power <= measured_power_count;
        end
        adj_cnt <= adj_cnt + 1'b1;
      end
    end
  end
endmodule // autoclass_channel

// >>> hw/autoclass_foldback_regs.v
// Operation
// - Manual measurement starts within 10 ms after its request bit is set.
// - Request bit cleared within 1 ms after the power result updates.
// - Request set before channel turn-on is ignored and cleared at turn-on.
// - Auto-adjust bit set: power cut threshold follows measured power.
// - Automatic threshold change done within 5 ms of measurement end.
// - Power registers read-only, bits 6 to 0, bit 7 reads zero.
// - Result is peak average power, counted in 0.5 W steps.
// - Channel 1 to 4 power results sit at commands 51h to 54h.
// - Upper foldback bits select alternative operating curve while powered.
// - Lower foldback bits select alternative inrush curve.
`timescale 1ns/1ps
`include "autoclass_defs.vh"
module autoclass_foldback_regs
(
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] cmd_addr,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_wdata,
  output reg [7:0] cmd_rdata,
  output wire cmd_hit,
  input wire [3:0] channel_on,
  input wire [3:0] channel_power_on_cmd,
  input wire [3:0] meas_busy,
  input wire [3:0] meas_done,
  input wire [27:0] measured_class_power,
  output wire [3:0] meas_start,
  output wire [3:0] pcut_adjust_valid,
  output wire [27:0] pcut_adjust_power,
  output wire [3:0] alt_operating_curve_en,
  output wire [3:0] alt_inrush_curve_en
);
  reg [7:0] autoclass_control;
  reg [7:0] alt_foldback_select;
  reg [3:0] turn_on_seen;
  wire [3:0] clear_request;
  wire [27:0] power_flat;
  wire [3:0] manual_measure_request;
  wire [3:0] threshold_auto_adjust_en;
  reg [3:0] next_request;
  reg [7:0] next_rdata;
  wire [7:0] ch1_autoclass_power;
  wire [7:0] ch2_autoclass_power;
  wire [7:0] ch3_autoclass_power;
  wire [7:0] ch4_autoclass_power;
  wire sel_control;
  wire sel_power;
  wire sel_foldback;

  assign manual_measure_request = autoclass_control[`REQ_MSB:`REQ_LSB];
  assign threshold_auto_adjust_en = autoclass_control[`ADJ_MSB:`ADJ_LSB];

  // Channel n uses bit n-1 of each 4-bit bus and lane n-1 of each 7-bit bus
  autoclass_channel u_ch1
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .request(manual_measure_request[0]),
    .auto_adjust(threshold_auto_adjust_en[0]),
    .channel_on(channel_on[0]),
    .turn_on_event(turn_on_seen[0]),
    .meas_busy(meas_busy[0]),
    .meas_done(meas_done[0]),
    .meas_power(measured_class_power[6:0]),
    .meas_start(meas_start[0]),
    .clear_request(clear_request[0]),
    .measured_power_count(power_flat[6:0]),
    .adjust_valid(pcut_adjust_valid[0]),
    .adjust_power(pcut_adjust_power[6:0])
  );

  autoclass_channel u_ch2
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .request(manual_measure_request[1]),
    .auto_adjust(threshold_auto_adjust_en[1]),
    .channel_on(channel_on[1]),
    .turn_on_event(turn_on_seen[1]),
    .meas_busy(meas_busy[1]),
    .meas_done(meas_done[1]),
    .meas_power(measured_class_power[13:7]),
    .meas_start(meas_start[1]),
    .clear_request(clear_request[1]),
    .measured_power_count(power_flat[13:7]),
    .adjust_valid(pcut_adjust_valid[1]),
    .adjust_power(pcut_adjust_power[13:7])
  );

  autoclass_channel u_ch3
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .request(manual_measure_request[2]),
    .auto_adjust(threshold_auto_adjust_en[2]),
    .channel_on(channel_on[2]),
    .turn_on_event(turn_on_seen[2]),
    .meas_busy(meas_busy[2]),
    .meas_done(meas_done[2]),
    .meas_power(measured_class_power[20:14]),
    .meas_start(meas_start[2]),
    .clear_request(clear_request[2]),
    .measured_power_count(power_flat[20:14]),
    .adjust_valid(pcut_adjust_valid[2]),
    .adjust_power(pcut_adjust_power[20:14])
  );

  autoclass_channel u_ch4
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .request(manual_measure_request[3]),
    .auto_adjust(threshold_auto_adjust_en[3]),
    .channel_on(channel_on[3]),
    .turn_on_event(turn_on_seen[3]),
    .meas_busy(meas_busy[3]),
    .meas_done(meas_done[3]),
    .meas_power(measured_class_power[27:21]),
    .meas_start(meas_start[3]),
    .clear_request(clear_request[3]),
    .measured_power_count(power_flat[27:21]),
    .adjust_valid(pcut_adjust_valid[3]),
    .adjust_power(pcut_adjust_power[27:21])
  );

  // Bit 7 of each power word has no storage behind it
  assign ch1_autoclass_power = {1'b0, power_flat[6:0]};
  assign ch2_autoclass_power = {1'b0, power_flat[13:7]};
  assign ch3_autoclass_power = {1'b0, power_flat[20:14]};
  assign ch4_autoclass_power = {1'b0, power_flat[27:21]};

  // Curve selects are plain levels; the power stage samples them at turn-on
  assign alt_operating_curve_en = alt_foldback_select[7:4] & channel_on;
  assign alt_inrush_curve_en = alt_foldback_select[3:0];

  // Register selects shared by the write path, the read path and the hit flag; sel_power feeds only the hit flag
  assign sel_control = (cmd_addr == `CMD_AUTOCLASS_CONTROL);
  assign sel_foldback = (cmd_addr == `CMD_ALT_FOLDBACK_SELECT);
  assign sel_power = (cmd_addr >= `CMD_CH1_AUTOCLASS_POWER) &&
                     (cmd_addr <= `CMD_CH4_AUTOCLASS_POWER);
  assign cmd_hit = sel_control || sel_power || sel_foldback;

  always @*
  begin
    // Host write first, then hardware clear so a clear in the same cycle lands
    next_request = manual_measure_request;
    if (cmd_wr && sel_control)
      next_request = cmd_wdata[`REQ_MSB:`REQ_LSB];
    next_request = next_request & ~clear_request;
  end

  // Request bits follow next_request; adjust bits change only on a host write
  always @(posedge mclk)
  begin
    if (sys_rst)
      autoclass_control <= `RST_AUTOCLASS_CONTROL;
    else
    begin
      autoclass_control[`REQ_MSB:`REQ_LSB] <= next_request;
      if (cmd_wr && sel_control)
        autoclass_control[`ADJ_MSB:`ADJ_LSB] <= cmd_wdata[`ADJ_MSB:`ADJ_LSB];
    end
  end

  // Whole byte is writable; the inrush half only matters before turn-on
  always @(posedge mclk)
  begin
    if (sys_rst)
      alt_foldback_select <= `RST_ALT_FOLDBACK_SELECT;
    else if (cmd_wr && sel_foldback)
      alt_foldback_select <= cmd_wdata;
  end

  // Turn-on pulse is registered once, so it meets the request bit a cycle late
  always @(posedge mclk)
  begin
    if (sys_rst)
      turn_on_seen <= 4'h0;
    else
      turn_on_seen <= channel_power_on_cmd;
  end

  // Decode first, then register, so read data stands until the next read
  always @*
  begin
    next_rdata = 8'h00;
    if (sel_control)
      next_rdata = autoclass_control;
    else if (cmd_addr == `CMD_CH1_AUTOCLASS_POWER)
      next_rdata = ch1_autoclass_power;
    else if (cmd_addr == `CMD_CH2_AUTOCLASS_POWER)
      next_rdata = ch2_autoclass_power;
    else if (cmd_addr == `CMD_CH3_AUTOCLASS_POWER)
      next_rdata = ch3_autoclass_power;
    else if (cmd_addr == `CMD_CH4_AUTOCLASS_POWER)
      next_rdata = ch4_autoclass_power;
    else if (sel_foldback)
      next_rdata = alt_foldback_select;
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
      cmd_rdata <= 8'h00;
    else if (cmd_rd)
      cmd_rdata <= next_rdata;
  end
endmodule // autoclass_foldback_regs

// >>> sim/acfr_chk.sv
`timescale 1ns/1ps
module acfr_chk
(
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] cmd_addr,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_wdata,
  input wire [7:0] cmd_rdata,
  input wire cmd_hit,
  input wire [3:0] channel_on,
  input wire [3:0] meas_busy,
  input wire [3:0] meas_start,
  input wire [3:0] pcut_adjust_valid,
  input wire [3:0] alt_operating_curve_en,
  input wire [3:0] alt_inrush_curve_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_start_after_req: assert property (cmd_wr && cmd_addr == 8'h50 && cmd_wdata[4] &&
    channel_on[0] && !meas_busy[0] |-> ##[1:4] meas_start[0]) else $error("no start");
  a_start_once: assert property (meas_start[0] |=> !meas_start[0]) else $error("long start");
  a_hit_map: assert property (cmd_hit == (cmd_addr >= 8'h50 && cmd_addr <= 8'h55))
    else $error("bad decode");
  a_ro_bit7: assert property (cmd_rd && cmd_addr >= 8'h51 && cmd_addr <= 8'h54
    |=> !cmd_rdata[7]) else $error("bit 7 set");
  a_unmapped_zero: assert property (cmd_rd && !cmd_hit |=> cmd_rdata == 8'h00)
    else $error("unmapped data");
  a_rdata_hold: assert property (!cmd_rd |=> $stable(cmd_rdata)) else $error("data moved");
  a_op_gated: assert property ((alt_operating_curve_en & ~channel_on) == 4'h0)
    else $error("curve while off");
  a_inrush_wr: assert property (cmd_wr && cmd_addr == 8'h55 |=>
    alt_inrush_curve_en == $past(cmd_wdata[3:0])) else $error("inrush bits");
  a_pcut_once: assert property (pcut_adjust_valid[0] |=> !pcut_adjust_valid[0])
    else $error("long adjust");
endmodule // acfr_chk
bind autoclass_foldback_regs acfr_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .cmd_addr(cmd_addr), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
  .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit), .channel_on(channel_on), .meas_busy(meas_busy),
  .meas_start(meas_start), .pcut_adjust_valid(pcut_adjust_valid),
  .alt_operating_curve_en(alt_operating_curve_en), .alt_inrush_curve_en(alt_inrush_curve_en));

// >>> sim/meas_engine_model.sv
`timescale 1ns/1ps
module meas_engine_model
(
  input wire mclk,
  input wire sys_rst,
  input wire [3:0] meas_start,
  output reg [3:0] meas_busy = 4'h0,
  output reg [3:0] meas_done = 4'h0,
  output reg [27:0] measured_class_power = 28'h0
);
  reg [7:0] cnt;
  reg [6:0] val;
  always @(posedge mclk)
  begin
    meas_done <= 4'h0;
    // Result lanes toggle outside the done pulse so a stale sample cannot pass
    measured_class_power <= ~measured_class_power;
    if (sys_rst)
    begin
      meas_busy <= 4'h0;
      cnt <= 8'h00;
      val <= 7'h2a;
      measured_class_power <= 28'h0;
    end
    else if (meas_busy != 4'h0)
    begin
      cnt <= cnt + 8'h01;
      if (cnt == 8'h28)
      begin
        meas_done <= meas_busy;
        measured_class_power <= {4{val}};
        meas_busy <= 4'h0;
        val <= val + 7'h01;
        cnt <= 8'h00;
      end
    end
    else if (meas_start != 4'h0)
      meas_busy <= meas_start;
  end
endmodule // meas_engine_model

// >>> sim/autoclass_foldback_regs_test.sv
`timescale 1ns/1ps
module autoclass_foldback_regs_test;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] cmd_addr = 8'h00;
  reg cmd_wr = 1'b0;
  reg cmd_rd = 1'b0;
  reg [7:0] cmd_wdata = 8'h00;
  reg [3:0] channel_on = 4'h0;
  reg [3:0] pwr_on = 4'h0;
  reg [7:0] rv = 8'h00;
  reg [7:0] pcut_seen = 8'h00;
  reg [6:0] pcut_last = 7'h00;
  wire [7:0] cmd_rdata;
  wire cmd_hit;
  wire [3:0] busy, done, start, pcut_valid, alt_op, alt_ir;
  wire [27:0] class_power, pcut_power;
  integer error_cnt = 0;
  integer checked = 0;
  integer i;
  autoclass_foldback_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_hit(cmd_hit), .channel_on(channel_on), .channel_power_on_cmd(pwr_on),
    .meas_busy(busy), .meas_done(done), .measured_class_power(class_power),
    .meas_start(start), .pcut_adjust_valid(pcut_valid), .pcut_adjust_power(pcut_power),
    .alt_operating_curve_en(alt_op), .alt_inrush_curve_en(alt_ir));
  meas_engine_model u_eng (.mclk(mclk), .sys_rst(sys_rst), .meas_start(start),
    .meas_busy(busy), .meas_done(done), .measured_class_power(class_power));
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk)
    if (pcut_valid[0] === 1'b1)
    begin
      pcut_seen <= pcut_seen + 8'h01;
      pcut_last <= pcut_power[6:0];
    end
  task check(input [7:0] seen, input [7:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge mclk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge mclk);
    cmd_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge mclk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge mclk);
    cmd_rd <= 1'b0;
    #1 rv = cmd_rdata;
  end
  endtask
  task results;
  begin
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (i = 8'h50; i < 8'h57; i = i + 1)
    begin
      rd(i[7:0]);
      check(rv, 8'h00);
    end
    wr(8'h51, 8'hff);
    rd(8'h51);
    check(rv, 8'h00);
    @(posedge mclk);
    channel_on <= 4'h3;
    wr(8'h55, 8'ha5);
    rd(8'h55);
    check(rv, 8'ha5);
    check({alt_op, alt_ir}, 8'h25);
    // Channel 3 is still off, so its request must die at turn-on
    wr(8'h50, 8'h40);
    @(posedge mclk);
    pwr_on <= 4'h4;
    @(posedge mclk);
    pwr_on <= 4'h0;
    repeat (3) @(posedge mclk);
    rd(8'h50);
    check(rv, 8'h00);
    wr(8'h50, 8'h11);
    for (i = 0; i < 200 && pcut_seen == 8'h00; i = i + 1)
      @(posedge mclk);
    check(pcut_seen, 8'h01);
    if (i == 200)
      results;
    check({1'b0, pcut_last}, 8'h2a);
    for (i = 0; i < 20 && rv !== 8'h01; i = i + 1)
      rd(8'h50);
    check(rv, 8'h01);
    rd(8'h51);
    check(rv, 8'h2a);
    wr(8'h50, 8'h10);
    for (i = 0; i < 40 && rv !== 8'h00; i = i + 1)
      rd(8'h50);
    check(rv, 8'h00);
    rd(8'h51);
    check(rv, 8'h2b);
    check(pcut_seen, 8'h01);
    repeat (20) @(posedge mclk);
    rd(8'h51);
    check(rv, 8'h2b);
    // Engine drives every lane; only channel 2 may take this result
    wr(8'h50, 8'h20);
    for (i = 0; i < 40 && rv !== 8'h00; i = i + 1)
      rd(8'h50);
    check(rv, 8'h00);
    rd(8'h52);
    check(rv, 8'h2c);
    rd(8'h51);
    check(rv, 8'h2b);
    rd(8'h53);
    check(rv, 8'h00);
    results;
  end
endmodule // autoclass_foldback_regs_test
